/* src/card_interrupt_steering.sv */
// Card interrupt steering, alternate pin functions and strobe ports.
// Assumes an AXI4-Lite master on clk; card pins asynchronous;
// card activity, ISA cycle and DMA request come from logic on clk.
`timescale 1ns/1ps
module card_interrupt_steering
  import card_irq_pkg::*;
#(
  parameter int NSOCK = 2,
  parameter int ADDR_W = 12,
  parameter int PULSE_CYC = SHARE_PULSE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [NSOCK-1:0] cardReadyIreqN,
  input wire logic [NSOCK-1:0] cardDetectN,
  input wire logic [NSOCK-1:0] cardSpeakerLedN,
  input wire logic [NSOCK-1:0] cardStatusRingN,
  input wire logic [NSOCK-1:0] cardActive,
  input wire logic [NSOCK-1:0] cardCycle,
  input wire logic isaCycle,
  input wire logic dmaRequest,
  input wire logic interrupt_pin_nine,
  input wire logic [7:0] gpPortIn,
  output logic [NUM_PINS-1:0] irqPinOut,
  output logic [NUM_PINS-1:0] irqPinOe,
  output logic dmaAckSeen,
  output logic [1:0] gpStrobe,
  output logic [7:0] gpPortOut,
  output logic irqOut
);

  localparam int EVW = EV_PER_SOCK * NSOCK;
  localparam int RAW_W = 4 * NSOCK + 9;
  localparam int CNT_W = $clog2(PULSE_CYC + 1);

  if (NSOCK < 1 || NSOCK > 2) $error("NSOCK must be 1 or 2");
  if (ADDR_W < IDX_W + IDX_LSB) $error("ADDR_W too small");
  if (PULSE_CYC < 1) $error("PULSE_CYC must be at least 1");

  function automatic logic [7:0] sockIdx(int s, logic [7:0] base);
    return 8'(base + s * IDX_SOCK_STRIDE);
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [RAW_W-1:0] rawMeta;
  logic [RAW_W-1:0] rawSync;
  logic [NSOCK-1:0] ireqS, detectS, speakerS, ringS;
  logic [NSOCK-1:0] detectPrev, speakerPrev, ringPrev, ireqPrev;
  logic [7:0] portS;
  logic dmaAckS;

  always_ff @(posedge clk) begin
    if (rst) begin
      rawMeta <= '1;
      rawSync <= '1;
    end else if (ce) begin
      rawMeta <= {cardReadyIreqN, cardDetectN, cardSpeakerLedN, cardStatusRingN,
                  gpPortIn, interrupt_pin_nine};
      rawSync <= rawMeta;
    end
  end

  assign {ireqS, detectS, speakerS, ringS, portS, dmaAckS} = rawSync;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg8_t intCtl [NSOCK];
  reg8_t mgmtSteer [NSOCK];
  reg8_t extCtl [NSOCK];
  reg8_t misc;
  reg8_t shareCtl;
  reg8_t strobeCfg;
  logic [EVW-1:0] status;
  logic [EVW-1:0] enable;

  logic [IDX_W-1:0] wIdx, rIdx;
  logic wOk, rOk, wrHit, rdHit, doWrite;
  logic [ADDR_W-1:0] awAddrHeld;
  logic [7:0] wByte;
  logic wLane;
  reg8_t rdValue;

  assign wIdx = awAddrHeld[IDX_LSB +: IDX_W];
  assign rIdx = araddr[IDX_LSB +: IDX_W];
  assign wOk = (awAddrHeld >> (IDX_LSB + IDX_W)) == '0;
  assign rOk = (araddr >> (IDX_LSB + IDX_W)) == '0;
  assign doWrite = !awready && !wready && !bvalid;

  function automatic logic isGlobal(logic [7:0] idx);
    return idx == IDX_MISC || idx == IDX_STATUS || idx == IDX_CLEAR || idx == IDX_ENABLE
        || idx == IDX_SHARE || idx == IDX_STB_CFG || idx == IDX_STB_PORT0
        || idx == IDX_STB_PORT1;
  endfunction

  always_comb begin
    wrHit = wOk && isGlobal(wIdx);
    rdHit = rOk && isGlobal(rIdx);
    rdValue = REG_RESET;
    case (rIdx)
      IDX_MISC: rdValue = misc;
      IDX_STATUS: rdValue = 8'(status);
      IDX_ENABLE: rdValue = 8'(enable);
      IDX_SHARE: rdValue = shareCtl;
      IDX_STB_CFG: rdValue = strobeCfg;
      IDX_STB_PORT0, IDX_STB_PORT1: rdValue = portS;
      default: rdValue = REG_RESET;
    endcase
    for (int s = 0; s < NSOCK; s++) begin
      if (wOk && (wIdx == sockIdx(s, IDX_INT_CTL) || wIdx == sockIdx(s, IDX_MGMT_STEER)
          || wIdx == sockIdx(s, IDX_EXT_BASE + IDX_EXT_CTL1))) wrHit = 1'b1;
      if (rOk && rIdx == sockIdx(s, IDX_INT_CTL)) begin
        rdHit = 1'b1;
        rdValue = intCtl[s];
      end
      if (rOk && rIdx == sockIdx(s, IDX_MGMT_STEER)) begin
        rdHit = 1'b1;
        rdValue = mgmtSteer[s];
      end
      if (rOk && rIdx == sockIdx(s, IDX_EXT_BASE + IDX_EXT_CTL1)) begin
        rdHit = 1'b1;
        rdValue = extCtl[s];
      end
    end
    if (!rdHit) rdValue = REG_RESET;
  end

  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      awAddrHeld <= '0;
      wByte <= 8'h00;
      wLane <= 1'b0;
    end else if (ce) begin
      if (awvalid && awready) begin
        awAddrHeld <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wByte <= wdata[7:0];
        wLane <= wstrb[0];
        wready <= 1'b0;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= {24'h00_0000, rdValue};
        rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // Only byte lane 0 carries register data
  always_ff @(posedge clk) begin
    if (rst) begin
      misc <= MISC_RESET;
      shareCtl <= REG_RESET;
      strobeCfg <= REG_RESET;
      enable <= '0;
      for (int s = 0; s < NSOCK; s++) begin
        intCtl[s] <= REG_RESET;
        mgmtSteer[s] <= REG_RESET;
        extCtl[s] <= REG_RESET;
      end
    end else if (ce && doWrite && wLane && wOk) begin
      case (wIdx)
        IDX_MISC: misc <= wByte;
        IDX_SHARE: shareCtl <= wByte;
        IDX_STB_CFG: strobeCfg <= wByte;
        IDX_ENABLE: enable <= wByte[EVW-1:0];
        default: ;
      endcase
      for (int s = 0; s < NSOCK; s++) begin
        if (wIdx == sockIdx(s, IDX_INT_CTL)) intCtl[s] <= wByte;
        if (wIdx == sockIdx(s, IDX_MGMT_STEER)) mgmtSteer[s] <= wByte;
        if (wIdx == sockIdx(s, IDX_EXT_BASE + IDX_EXT_CTL1)) extCtl[s] <= wByte;
      end
    end
  end

  // ------------------------------------------------------------
  // Management events and status
  // ------------------------------------------------------------
  logic [EVW-1:0] events;
  logic [EVW-1:0] clearMask;
  logic [NSOCK-1:0] cardIo, cardReq, mgmtPend, ringEn, actEn;

  always_comb begin
    events = '0;
    for (int s = 0; s < NSOCK; s++) begin
      cardIo[s] = intCtl[s][INT_IO_BIT];
      ringEn[s] = intCtl[s][INT_RING_EN_BIT];
      actEn[s] = extCtl[s][EXT_ACT_EN_BIT];
      // Card class only from a present, activated I/O card
      cardReq[s] = cardActive[s] && cardIo[s] && !ireqS[s];
      events[s * EV_PER_SOCK + EV_DETECT] = detectS[s] != detectPrev[s];
      events[s * EV_PER_SOCK + EV_BVD2] = !cardIo[s] && speakerS[s] != speakerPrev[s];
      events[s * EV_PER_SOCK + EV_BVD1] = ringS[s] != ringPrev[s];
      events[s * EV_PER_SOCK + EV_RDY] = !cardIo[s] && ireqS[s] != ireqPrev[s];
      mgmtPend[s] = |(status[s * EV_PER_SOCK +: EV_PER_SOCK]
                      & enable[s * EV_PER_SOCK +: EV_PER_SOCK]);
    end
  end

  assign clearMask = (ce && doWrite && wLane && wOk && wIdx == IDX_CLEAR) ? wByte[EVW-1:0] : '0;

  // New events win over a simultaneous clear
  always_ff @(posedge clk) begin
    if (rst) begin
      status <= '0;
      irqOut <= 1'b0;
      detectPrev <= '1;
      speakerPrev <= '1;
      ringPrev <= '1;
      ireqPrev <= '1;
    end else if (ce) begin
      status <= (status & ~clearMask) | events;
      irqOut <= |(status & enable);
      detectPrev <= detectS;
      speakerPrev <= speakerS;
      ringPrev <= ringS;
      ireqPrev <= ireqS;
    end
  end

  // ------------------------------------------------------------
  // Steering and alternate functions
  // ------------------------------------------------------------
  logic [NUM_PINS-1:0] pinUsed, pinDrive, reqPrev;
  logic [NUM_PINS-1:0] next_pinOut, next_pinOe;
  logic [CNT_W-1:0] shareCnt [NUM_PINS];
  logic ledMode, ledOn, ringSel, ringCause, ringHold, dmaMode, shareEn;

  assign shareEn = shareCtl[SHARE_EN_BIT];
  assign dmaMode = misc[MISC_DMA_BIT];
  assign ringSel = misc[MISC_RING_SEL_BIT];
  assign ledMode = |actEn || misc[MISC_DRIVE_LED_BIT];
  // Suspend bits are not consulted, so pass-through continues
  assign ringCause = ringSel && |(cardActive & cardIo & ringEn & ~ringS);

  always_comb begin
    ledOn = 1'b0;
    for (int s = 0; s < NSOCK; s++) begin
      if (cardActive[s] && actEn[s] && cardCycle[s]) ledOn = 1'b1;
      if (cardActive[s] && cardIo[s] && misc[MISC_DRIVE_LED_BIT] && !speakerS[s]) begin
        ledOn = 1'b1;
      end
    end
  end

  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      pinUsed[p] = 1'b0;
      pinDrive[p] = 1'b0;
      for (int s = 0; s < NSOCK; s++) begin
        if (intCtl[s][SEL_LSB +: SEL_W] == pin_sel_t'(p + 1)) begin
          pinUsed[p] = 1'b1;
          pinDrive[p] = pinDrive[p] | cardReq[s];
        end
        if (mgmtSteer[s][SEL_LSB +: SEL_W] == pin_sel_t'(p + 1)) begin
          pinUsed[p] = 1'b1;
          pinDrive[p] = pinDrive[p] | mgmtPend[s];
        end
      end
      if (shareEn) begin
        next_pinOut[p] = 1'b1;
        next_pinOe[p] = shareCnt[p] != '0;
      end else begin
        next_pinOut[p] = pinDrive[p];
        next_pinOe[p] = pinUsed[p];
      end
    end
    if (ledMode) begin
      next_pinOut[PIN_TWELVE] = 1'b0;
      next_pinOe[PIN_TWELVE] = ledOn;
    end
    if (ringSel) begin
      next_pinOut[PIN_FIFTEEN] = !ringHold;
      next_pinOe[PIN_FIFTEEN] = 1'b1;
    end
    // Pin roles only; no card transfer is started here
    if (dmaMode) begin
      next_pinOut[PIN_NINE] = 1'b0;
      next_pinOe[PIN_NINE] = 1'b0;
      next_pinOut[PIN_TEN] = dmaRequest;
      next_pinOe[PIN_TEN] = 1'b1;
    end
  end

  // Share pulse restarts only on a new request edge
  always_ff @(posedge clk) begin
    if (rst) begin
      reqPrev <= '0;
      for (int p = 0; p < NUM_PINS; p++) shareCnt[p] <= '0;
    end else if (ce) begin
      reqPrev <= pinDrive;
      for (int p = 0; p < NUM_PINS; p++) begin
        if (pinDrive[p] && !reqPrev[p]) shareCnt[p] <= CNT_W'(PULSE_CYC);
        else if (shareCnt[p] != '0) shareCnt[p] <= shareCnt[p] - 1'b1;
      end
    end
  end

  // One ring gives one wake event, held until an ISA cycle; a ring still held keeps it set
  always_ff @(posedge clk) begin
    if (rst) begin
      ringHold <= 1'b0;
    end else if (ce) begin
      if (ringCause) ringHold <= 1'b1;
      else if (isaCycle) ringHold <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irqPinOut <= '0;
      irqPinOe <= '0;
      dmaAckSeen <= 1'b0;
    end else if (ce) begin
      irqPinOut <= next_pinOut;
      irqPinOe <= next_pinOe;
      dmaAckSeen <= dmaMode && !dmaAckS;
    end
  end

  // ------------------------------------------------------------
  // Strobe ports
  // ------------------------------------------------------------
  logic [1:0] stbWrite, stbRead;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      stbWrite[i] = doWrite && wOk && wIdx == 8'(IDX_STB_PORT0 + i)
                    && strobeCfg[i * STB_FIELD_W + STB_EN_BIT]
                    && !strobeCfg[i * STB_FIELD_W + STB_READ_BIT];
      stbRead[i] = arvalid && arready && rIdx == 8'(IDX_STB_PORT0 + i) && rOk
                   && strobeCfg[i * STB_FIELD_W + STB_EN_BIT]
                   && strobeCfg[i * STB_FIELD_W + STB_READ_BIT];
    end
  end

  // Access completes in one cycle, so the strobe is one cycle long
  always_ff @(posedge clk) begin
    if (rst) begin
      gpStrobe <= 2'b00;
      gpPortOut <= 8'h00;
    end else if (ce) begin
      gpStrobe <= stbWrite | stbRead;
      if (|stbWrite && wLane) gpPortOut <= wByte;
    end
  end

endmodule

/* src/card_irq_pkg.sv */
// Constants shared by the card interrupt steering block.
// Assumes a 250 MHz register clock and up to two card sockets.
package card_irq_pkg;

  // ------------------------------------------------------------
  // Pins
  // ------------------------------------------------------------
  localparam int NUM_PINS = 10;
  localparam int PIN_NINE = 4;
  localparam int PIN_TEN = 5;
  localparam int PIN_TWELVE = 7;
  localparam int PIN_FIFTEEN = 9;

  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_INT_CTL = 8'h03;
  localparam logic [7:0] IDX_MGMT_STEER = 8'h05;
  localparam logic [7:0] IDX_MISC = 8'h1e;
  localparam logic [7:0] IDX_EXT_BASE = 8'h80;
  localparam logic [7:0] IDX_EXT_CTL1 = 8'h03;
  localparam logic [7:0] IDX_SOCK_STRIDE = 8'h40;
  localparam logic [7:0] IDX_STATUS = 8'h30;
  localparam logic [7:0] IDX_CLEAR = 8'h31;
  localparam logic [7:0] IDX_ENABLE = 8'h32;
  localparam logic [7:0] IDX_SHARE = 8'h33;
  localparam logic [7:0] IDX_STB_CFG = 8'h34;
  localparam logic [7:0] IDX_STB_PORT0 = 8'h35;
  localparam logic [7:0] IDX_STB_PORT1 = 8'h36;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 8;

  // ------------------------------------------------------------
  // Fields
  // ------------------------------------------------------------
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 4;
  localparam int INT_IO_BIT = 5;
  localparam int INT_RING_EN_BIT = 7;
  localparam int EXT_ACT_EN_BIT = 2;
  localparam int MISC_DRIVE_LED_BIT = 4;
  localparam int MISC_DMA_BIT = 6;
  localparam int MISC_RING_SEL_BIT = 7;
  localparam int SHARE_EN_BIT = 0;
  localparam int STB_EN_BIT = 0;
  localparam int STB_READ_BIT = 1;
  localparam int STB_FIELD_W = 2;
  localparam int EV_DETECT = 0;
  localparam int EV_BVD2 = 1;
  localparam int EV_BVD1 = 2;
  localparam int EV_RDY = 3;
  localparam int EV_PER_SOCK = 4;

  // ------------------------------------------------------------
  // Reset values, responses, timing
  // ------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] MISC_RESET = 8'h02;
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SHARE_PULSE_NS = 40;
  localparam int SHARE_PULSE_CYC = (SHARE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef logic [7:0] reg8_t;
  typedef logic [SEL_W-1:0] pin_sel_t;

endpackage

/* tb/card_interrupt_steering_tb.sv */
// Self-checking bench for card_interrupt_steering.
// Assumes checker and system model are compiled first.
`timescale 1ns/1ps
module card_interrupt_steering_tb;
  import card_irq_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, isaCycle = 1'b0, dmaRequest = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata, d, r;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] cardReadyIreqN = 2'h3, cardDetectN = 2'h3, cardSpeakerLedN = 2'h3;
  logic [1:0] cardStatusRingN = 2'h3, cardActive = 2'h3, cardCycle = 2'h0;
  logic [7:0] gpPortIn = 8'h0, gpPortOut;
  logic awready, wready, bvalid, arready, rvalid, dmaAckSeen, irqOut, dackN;
  logic [1:0] bresp, rresp, gpStrobe, stbSeen;
  logic [NUM_PINS-1:0] irqPinOut, irqPinOe, pinLevel;
  int err_total = 0, n_tests = 0, cnt;
  always #2 clk = ~clk;
  // Short share pulse keeps the count check quick
  card_interrupt_steering #(.NSOCK(2), .PULSE_CYC(3)) DUT (.clk, .rst, .ce, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .cardReadyIreqN, .cardDetectN,
    .cardSpeakerLedN, .cardStatusRingN, .cardActive, .cardCycle, .isaCycle, .dmaRequest,
    .interrupt_pin_nine(dackN), .gpPortIn, .irqPinOut, .irqPinOe, .dmaAckSeen, .gpStrobe,
    .gpPortOut, .irqOut);
  isa_system_model sys (.clk, .rst, .pinOut(irqPinOut), .pinOe(irqPinOe), .pinLevel, .dackN);
  always @(posedge clk) stbSeen |= gpStrobe;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    @(posedge clk);
    awaddr <= {2'b00, i, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    r = {30'h0, bresp};
  endtask
  task automatic rd(input logic [7:0] i);
    @(posedge clk);
    araddr <= {2'b00, i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = {30'h0, rresp};
  endtask
  task automatic t_regs;
    rd(IDX_MISC);
    chk(d, 32'(MISC_RESET));
    rd(8'h3f);
    chk(r, 32'(RESP_SLVERR));
    wr(8'h3f, 8'hff);
    chk(r, 32'(RESP_SLVERR));
    $display("regs done");
  endtask
  task automatic t_steer;
    cardReadyIreqN <= 2'b10;
    for (int c = 1; c <= NUM_PINS; c++) begin
      wr(IDX_INT_CTL, 8'h20 | 8'(c));
      wt(6);
      chk(32'(irqPinOe), 32'h1 << (c - 1));
      chk(32'(irqPinOut), 32'h1 << (c - 1));
    end
    cardReadyIreqN <= 2'b00;
    wr(IDX_INT_CTL + IDX_SOCK_STRIDE, 8'h21);
    wt(6);
    chk(32'(irqPinOe), 32'h201);
    wr(IDX_INT_CTL + IDX_SOCK_STRIDE, 8'h20);
    wr(IDX_INT_CTL, 8'h20);
    wt(3);
    chk(32'(irqPinOe), 32'h0);
    cardReadyIreqN <= 2'b11;
    $display("steer done");
  endtask
  task automatic t_mgmt;
    wr(IDX_ENABLE, 8'h01);
    wr(IDX_MGMT_STEER, 8'h01);
    cardDetectN <= 2'b10;
    wt(6);
    chk(32'(irqOut), 32'h1);
    chk(32'(irqPinOe), 32'h1);
    chk(32'(irqPinOut), 32'h1);
    wr(IDX_ENABLE, 8'h00);
    wr(IDX_STATUS, 8'h00);
    wt(2);
    chk(32'(irqOut), 32'h0);
    rd(IDX_STATUS);
    chk(d & 32'h1, 32'h1);
    wr(IDX_CLEAR, 8'h01);
    wr(IDX_ENABLE, 8'h01);
    wt(2);
    chk(32'(irqOut), 32'h0);
    chk(32'(irqPinOe), 32'h1);
    chk(32'(irqPinOut), 32'h0);
    wr(IDX_MGMT_STEER, 8'h00);
    $display("mgmt done");
  endtask
  task automatic t_share;
    wr(IDX_SHARE, 8'h01);
    wr(IDX_INT_CTL, 8'h21);
    cardReadyIreqN <= 2'b10;
    cnt = 0;
    repeat (12) begin
      @(posedge clk);
      cnt += int'(irqPinOe[0]);
    end
    chk(cnt, 32'd3);
    chk(32'(irqPinOe), 32'h0);
    cardReadyIreqN <= 2'b11;
    wr(IDX_SHARE, 8'h00);
    wr(IDX_INT_CTL, 8'h00);
    $display("share done");
  endtask
  task automatic t_led;
    wr(IDX_EXT_BASE + IDX_EXT_CTL1, 8'h04);
    cardCycle <= 2'b01;
    wt(3);
    chk(32'(irqPinOe[PIN_TWELVE]), 32'h1);
    chk(32'(pinLevel[PIN_TWELVE]), 32'h0);
    cardActive <= 2'b10;
    wt(3);
    chk(32'(irqPinOe[PIN_TWELVE]), 32'h0);
    cardActive <= 2'b11;
    cardCycle <= 2'b00;
    wr(IDX_EXT_BASE + IDX_EXT_CTL1, 8'h00);
    wr(IDX_MISC, MISC_RESET | 8'h10);
    cardSpeakerLedN <= 2'b01;
    wt(6);
    chk(32'(irqPinOe[PIN_TWELVE]), 32'h1);
    cardSpeakerLedN <= 2'b11;
    wt(6);
    chk(32'(irqPinOe[PIN_TWELVE]), 32'h0);
    wr(IDX_MISC, MISC_RESET);
    $display("led done");
  endtask
  task automatic t_ring;
    wr(IDX_MISC, MISC_RESET | 8'h80);
    wr(IDX_INT_CTL, 8'ha0);
    cardStatusRingN <= 2'b10;
    wt(6);
    chk(32'(pinLevel[PIN_FIFTEEN]), 32'h0);
    cardStatusRingN <= 2'b11;
    wt(6);
    chk(32'(pinLevel[PIN_FIFTEEN]), 32'h0);
    isaCycle <= 1'b1;
    @(posedge clk);
    isaCycle <= 1'b0;
    wt(3);
    chk(32'(pinLevel[PIN_FIFTEEN]), 32'h1);
    chk(32'(irqPinOe[PIN_FIFTEEN]), 32'h1);
    wr(IDX_INT_CTL, 8'h20);
    cardStatusRingN <= 2'b10;
    wt(6);
    chk(32'(pinLevel[PIN_FIFTEEN]), 32'h1);
    cardStatusRingN <= 2'b11;
    wr(IDX_MISC, MISC_RESET);
    $display("ring done");
  endtask
  task automatic t_dma;
    wr(IDX_MISC, MISC_RESET | 8'h40);
    wt(3);
    chk(32'(irqPinOut[PIN_TEN]), 32'h0);
    dmaRequest <= 1'b1;
    wt(8);
    chk(32'(irqPinOe[PIN_NINE]), 32'h0);
    chk(32'(irqPinOe[PIN_TEN] & irqPinOut[PIN_TEN]), 32'h1);
    chk(32'(dmaAckSeen), 32'h1);
    dmaRequest <= 1'b0;
    wt(8);
    chk(32'(dmaAckSeen), 32'h0);
    wr(IDX_MISC, MISC_RESET);
    wt(2);
    chk(32'(irqPinOe), 32'h0);
    $display("dma done");
  endtask
  task automatic t_stb;
    wr(IDX_STB_CFG, 8'h0d);
    gpPortIn <= 8'h3c;
    stbSeen = 2'b00;
    wr(IDX_STB_PORT0, 8'ha5);
    wt(1);
    chk(32'(stbSeen), 32'h1);
    chk(32'(gpPortOut), 32'ha5);
    stbSeen = 2'b00;
    wr(IDX_STB_PORT1, 8'h11);
    rd(IDX_STB_PORT1);
    wt(1);
    chk(d, 32'h3c);
    chk(32'(stbSeen), 32'h2);
    $display("strobe done");
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    wt(10);
    rst <= 1'b0;
    t_regs;
    t_steer;
    t_mgmt;
    t_share;
    t_led;
    t_ring;
    t_dma;
    t_stb;
    end_sim;
  end
  initial begin
    wt(20000);
    err_total++;
    end_sim;
  end
endmodule

/* tb/card_irq_checker.sv */
// Port-level assertions for card_interrupt_steering.
// Assumes one clock domain; ce high whenever rules are judged.
`timescale 1ns/1ps
module card_irq_checker
  import card_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic dmaRequest,
  input wire logic [NUM_PINS-1:0] irqPinOut,
  input wire logic [NUM_PINS-1:0] irqPinOe,
  input wire logic dmaAckSeen,
  input wire logic [1:0] gpStrobe,
  input wire logic irqOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst || !ce);
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_w_ans; awvalid && awready && wvalid && wready |=> ##1 bvalid; endproperty
  a_w_ans: assert property (p_w_ans) else $error("write response late");
  property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_ans; arvalid && arready |=> rvalid; endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
  property p_r_upper; rvalid |-> rdata[31:8] == 24'h0; endproperty
  a_r_upper: assert property (p_r_upper) else $error("read upper bits set");
  property p_r_err; rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0; endproperty
  a_r_err: assert property (p_r_err) else $error("error read carries data");
  property p_dma_in; dmaAckSeen |-> !irqPinOe[PIN_NINE]; endproperty
  a_dma_in: assert property (p_dma_in) else $error("pin nine driven in dma mode");
  property p_drq;
    dmaAckSeen |-> irqPinOe[PIN_TEN] && irqPinOut[PIN_TEN] == $past(dmaRequest);
  endproperty
  a_drq: assert property (p_drq) else $error("request pin not following");
  property p_stb;
    gpStrobe != 2'b00 |-> ($rose(bvalid) || $rose(rvalid)) ##1 gpStrobe == 2'b00;
  endproperty
  a_stb: assert property (p_stb) else $error("strobe not a single pulse");
  c_dma: cover property (dmaAckSeen);
  c_stb_w: cover property (gpStrobe[0]);
  c_stb_r: cover property (gpStrobe[1]);
  c_irq: cover property (irqOut);
endmodule
bind card_interrupt_steering card_irq_checker u_chk (.clk, .rst, .ce, .awvalid, .awready,
  .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rresp, .rvalid,
  .rready, .dmaRequest, .irqPinOut, .irqPinOe, .dmaAckSeen, .gpStrobe, .irqOut);

/* tb/isa_system_model.sv */
// System side: pulled-up interrupt lines and a DMA acknowledge source.
// Assumes the pin index order of card_irq_pkg.
`timescale 1ns/1ps
module isa_system_model
  import card_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [NUM_PINS-1:0] pinOut,
  input wire logic [NUM_PINS-1:0] pinOe,
  output logic [NUM_PINS-1:0] pinLevel,
  output logic dackN
);
  // Released lines rise to the pull-up, never keep the last value
  assign pinLevel = (pinOut & pinOe) | ~pinOe;
  always_ff @(posedge clk) begin
    if (rst) begin
      dackN <= 1'b1;
    end else begin
      dackN <= ~(pinOe[PIN_TEN] & pinOut[PIN_TEN]);
    end
  end
endmodule
